// >>> core/acs_map.svh
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
// Register addresses on the plain port.
`define ACS_ADDR_CTRL0 4'h0
`define ACS_ADDR_CTRL1 4'h1
`define ACS_ADDR_RES_HI 4'h2
`define ACS_ADDR_RES_LO 4'h3
`define ACS_ADDR_INT_STAT 4'h4
`define ACS_ADDR_INT_MASK 4'h5
// Control register 0 fields.
`define ACS_C0_START 7
`define ACS_C0_BUSY 6
`define ACS_C0_PWR 5
`define ACS_C0_ALIGN 4
`define ACS_C0_CH_HI 2
`define ACS_C0_CH_LO 0
// Control register 1 fields.
`define ACS_C1_BGEN 5
`define ACS_C1_REF_HI 4
`define ACS_C1_REF_LO 3
`define ACS_C1_DIV_HI 2
`define ACS_C1_DIV_LO 0
// Interrupt status and mask fields.
`define ACS_INT_EOC 0
// Reset values.
`define ACS_RST_BYTE 8'h00
`define ACS_RST_DIV 3'h0
// Conversion timing in converter clock cycles.
`define ACS_SAMPLE_CYC 5'h04
`define ACS_TOTAL_CYC 5'h10
// Encodings.
`define ACS_REF_EXT_PIN 2'h1
`define ACS_REF_INT_AMP 2'h2
`define ACS_CH_OVERCURRENT 3'h2
`define ACS_CODE_ZERO 12'h000
`endif

// >>> core/acs_pkg.sv
package acs_pkg;
  typedef enum logic [1:0]
  {
    ACS_IDLE = 2'h0,
    ACS_ARMED = 2'h1,
    ACS_SAMPLE = 2'h3,
    ACS_CONVERT = 2'h2
  } acs_state_t;
  typedef logic [7:0] acs_byte_t;
  typedef logic [11:0] acs_code_t;
endpackage

// >>> core/acs_clkdiv.sv
`timescale 1ns/1ns
`default_nettype none
`include "acs_map.svh"
module acs_clkdiv
#(
  parameter int SEL_W = 3
)
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Control.
  input wire logic run,
  input wire logic [SEL_W-1:0] sel,
  // One system cycle pulse per converter clock period.
  output logic tick
);
  localparam int CNT_W = (1 << SEL_W) - 1;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] limit;

  // Code n divides by two to the n; the counter wraps at that ratio.
  assign limit = CNT_W'((1 << sel) - 1);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      cnt_q <= '0;
    else if (!run || cnt_q >= limit)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 1'b1;
  end

  assign tick = run && (cnt_q >= limit);
endmodule // acs_clkdiv
`default_nettype wire

// >>> core/acs_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
`include "acs_map.svh"
// Operation
// - A start bit pulse high then low begins a new conversion.
// - Hardware sets the busy flag once a conversion is launched.
// - Busy flag clears when the conversion completes.
// - Completion sets the interrupt request; enabled requests raise the interrupt.
// - Converter clock is system clock divided by two to the select code.
// - Power enable must be high to convert; software waits settling first.
// - Sampling takes 4 converter clocks, conversion 12, total 16.
// - Internal reference choice disconnects the external reference pin.
// - Result registers hold the code once busy has dropped.
// - Result is a 12-bit unsigned code, full scale FFFH.
// - Clearing power enable switches the converter circuitry off.
// - Ideal code transitions sit half a step low; core realises this.
// - Channel code 010 routes the overcurrent amplifier output to the core.
// - Align bit selects 8+4 or 4+8 split across result bytes.
// - Clearing power enable zeroes both result registers.
module acs_sequencer
  import acs_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output acs_pkg::acs_byte_t reg_rdata,
  // Interrupt.
  output logic conv_irq,
  // Converter core.
  output logic core_power_on,
  output logic core_sample,
  output logic core_convert,
  output logic core_clk_tick,
  output logic [2:0] input_channel_sel,
  output logic sel_overcurrent_amp_output,
  output logic [1:0] ref_source_sel,
  output logic ext_ref_connect,
  output logic bandgap_enable,
  input wire logic core_done,
  input wire logic [11:0] core_code
);
  import acs_pkg::*;

  acs_state_t state_q;
  logic start_q;
  logic conv_power_enable_q;
  logic result_align_sel_q;
  logic [2:0] ch_q;
  logic [1:0] ref_q;
  logic bgen_q;
  logic [2:0] conv_clock_divider_sel_q;
  logic conv_busy_flag_q;
  acs_byte_t result_high_byte_q;
  acs_byte_t result_low_byte_q;
  logic int_stat_q;
  logic int_mask_q;
  logic [4:0] cyc_q;
  acs_code_t code_q;
  acs_byte_t rdata_q;
  logic irq_q;
  logic core_sample_q;
  logic core_convert_q;
  logic core_tick_q;
  logic core_pwr_q;
  logic ext_ref_q;
  logic ovc_q;
  logic tick;
  logic wr_c0;
  logic wr_c1;
  logic start_rise;
  logic start_fall;
  logic done_evt;
  logic clr_eoc;

  assign wr_c0 = reg_wr && reg_addr == `ACS_ADDR_CTRL0;
  assign wr_c1 = reg_wr && reg_addr == `ACS_ADDR_CTRL1;
  assign start_rise = wr_c0 && reg_wdata[`ACS_C0_START] && !start_q;
  assign start_fall = wr_c0 && !reg_wdata[`ACS_C0_START] && start_q;
  assign clr_eoc = reg_wr && reg_addr == `ACS_ADDR_INT_STAT
    && reg_wdata[`ACS_INT_EOC];

  // Run the divider only while a conversion is counting, so phase is fixed.
  acs_clkdiv
  #(
    .SEL_W(3)
  )
  u_div
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(state_q == ACS_SAMPLE || state_q == ACS_CONVERT),
    .sel(conv_clock_divider_sel_q),
    .tick(tick)
  );

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      start_q <= 1'b0;
      conv_power_enable_q <= 1'b0;
      result_align_sel_q <= 1'b0;
      ch_q <= 3'h0;
    end
    else if (wr_c0)
    begin
      start_q <= reg_wdata[`ACS_C0_START];
      conv_power_enable_q <= reg_wdata[`ACS_C0_PWR];
      result_align_sel_q <= reg_wdata[`ACS_C0_ALIGN];
      ch_q <= reg_wdata[`ACS_C0_CH_HI:`ACS_C0_CH_LO];
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      bgen_q <= 1'b0;
      ref_q <= 2'h0;
      conv_clock_divider_sel_q <= `ACS_RST_DIV;
    end
    else if (wr_c1)
    begin
      bgen_q <= reg_wdata[`ACS_C1_BGEN];
      ref_q <= reg_wdata[`ACS_C1_REF_HI:`ACS_C1_REF_LO];
      conv_clock_divider_sel_q <= reg_wdata[`ACS_C1_DIV_HI:`ACS_C1_DIV_LO];
    end
  end

  // Sequencer. A cleared power bit aborts everything, since the core is off.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ACS_IDLE;
      cyc_q <= 5'h00;
    end
    else if (!conv_power_enable_q)
    begin
      state_q <= ACS_IDLE;
      cyc_q <= 5'h00;
    end
    else if (start_rise)
    begin
      state_q <= ACS_ARMED;
      cyc_q <= 5'h00;
    end
    else
    begin
      unique case (state_q)
        ACS_IDLE:
        begin
          cyc_q <= 5'h00;
        end
        ACS_ARMED:
        begin
          cyc_q <= 5'h00;
          if (start_fall)
            state_q <= ACS_SAMPLE;
        end
        ACS_SAMPLE:
        begin
          if (tick)
          begin
            cyc_q <= cyc_q + 5'h01;
            if (cyc_q + 5'h01 == `ACS_SAMPLE_CYC)
              state_q <= ACS_CONVERT;
          end
        end
        ACS_CONVERT:
        begin
          if (tick)
          begin
            cyc_q <= cyc_q + 5'h01;
            if (cyc_q + 5'h01 == `ACS_TOTAL_CYC)
              state_q <= ACS_IDLE;
          end
        end
      endcase
    end
  end

  // The sequencer owns completion timing; core_done only latches the code.
  assign done_evt = conv_power_enable_q && !start_rise
    && state_q == ACS_CONVERT && tick && cyc_q + 5'h01 == `ACS_TOTAL_CYC;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      code_q <= `ACS_CODE_ZERO;
    else if (state_q == ACS_CONVERT && core_done)
      code_q <= core_code;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      conv_busy_flag_q <= 1'b0;
    else if (!conv_power_enable_q || start_rise)
      conv_busy_flag_q <= 1'b0;
    else if (state_q == ACS_ARMED && start_fall)
      conv_busy_flag_q <= 1'b1;
    else if (done_evt)
      conv_busy_flag_q <= 1'b0;
  end

  // Results land in the same edge a completion drops busy, so a poll after completion never sees stale data.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      result_high_byte_q <= `ACS_RST_BYTE;
      result_low_byte_q <= `ACS_RST_BYTE;
    end
    else if (!conv_power_enable_q)
    begin
      result_high_byte_q <= `ACS_RST_BYTE;
      result_low_byte_q <= `ACS_RST_BYTE;
    end
    else if (done_evt && result_align_sel_q)
    begin
      result_high_byte_q <= {4'h0, code_q[11:8]};
      result_low_byte_q <= code_q[7:0];
    end
    else if (done_evt)
    begin
      result_high_byte_q <= code_q[11:4];
      result_low_byte_q <= {code_q[3:0], 4'h0};
    end
  end

  // A completion in the same cycle as a clear keeps the flag set.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      int_stat_q <= 1'b0;
    else if (done_evt)
      int_stat_q <= 1'b1;
    else if (clr_eoc)
      int_stat_q <= 1'b0;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      int_mask_q <= 1'b0;
    else if (reg_wr && reg_addr == `ACS_ADDR_INT_MASK)
      int_mask_q <= reg_wdata[`ACS_INT_EOC];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq_q <= 1'b0;
    else
      irq_q <= (int_stat_q || done_evt) && int_mask_q;
  end

  // Analog control lines, all registered.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      core_pwr_q <= 1'b0;
      core_sample_q <= 1'b0;
      core_convert_q <= 1'b0;
      core_tick_q <= 1'b0;
      ext_ref_q <= 1'b0;
      ovc_q <= 1'b0;
    end
    else
    begin
      core_pwr_q <= conv_power_enable_q;
      core_sample_q <= state_q == ACS_SAMPLE;
      core_convert_q <= state_q == ACS_CONVERT;
      core_tick_q <= tick;
      ext_ref_q <= conv_power_enable_q && ref_q == `ACS_REF_EXT_PIN;
      ovc_q <= ch_q == `ACS_CH_OVERCURRENT;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdata_q <= `ACS_RST_BYTE;
    else if (!reg_rd)
      rdata_q <= `ACS_RST_BYTE;
    else
    begin
      unique case (reg_addr)
        `ACS_ADDR_CTRL0:
          rdata_q <= {start_q, conv_busy_flag_q, conv_power_enable_q,
            result_align_sel_q, 1'b0, ch_q};
        `ACS_ADDR_CTRL1:
          rdata_q <= {2'h0, bgen_q, ref_q, conv_clock_divider_sel_q};
        `ACS_ADDR_RES_HI:
          rdata_q <= result_high_byte_q;
        `ACS_ADDR_RES_LO:
          rdata_q <= result_low_byte_q;
        `ACS_ADDR_INT_STAT:
          rdata_q <= {7'h00, int_stat_q};
        `ACS_ADDR_INT_MASK:
          rdata_q <= {7'h00, int_mask_q};
        default:
          rdata_q <= `ACS_RST_BYTE;
      endcase
    end
  end

  assign reg_rdata = rdata_q;
  assign conv_irq = irq_q;
  assign core_power_on = core_pwr_q;
  assign core_sample = core_sample_q;
  assign core_convert = core_convert_q;
  assign core_clk_tick = core_tick_q;
  assign input_channel_sel = ch_q;
  assign sel_overcurrent_amp_output = ovc_q;
  assign ref_source_sel = ref_q;
  assign ext_ref_connect = ext_ref_q;
  assign bandgap_enable = bgen_q;
endmodule // acs_sequencer
`default_nettype wire

// >>> bench/acs_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module acs_core_model
(
  // Controls from the sequencer; the code value from the bench.
  input wire logic core_power_on,
  input wire logic core_convert,
  input wire logic [11:0] code_val,
  // Answer to the sequencer.
  output logic core_done,
  output logic [11:0] core_code
);
  // Outside the convert phase the code lines show the inverse value.
  // A stale latch then cannot pass for a fresh one.
  always_comb
  begin
    core_done = core_power_on && core_convert;
    core_code = core_done ? code_val : ~code_val;
  end
endmodule // acs_core_model
`default_nettype wire

// >>> bench/acs_sequencer_sva.sv
`timescale 1ns/1ns
`default_nettype none
module acs_sva
  import acs_pkg::*;
(
  // Clock, reset and register port.
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire acs_pkg::acs_byte_t reg_rdata,
  // Interrupt and core side.
  input wire logic conv_irq,
  input wire logic core_power_on,
  input wire logic core_sample,
  input wire logic core_convert,
  input wire logic core_clk_tick,
  input wire logic [2:0] input_channel_sel,
  input wire logic sel_overcurrent_amp_output,
  input wire logic [1:0] ref_source_sel,
  input wire logic ext_ref_connect,
  input wire logic bandgap_enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_phase_excl: assert property (!(core_sample && core_convert))
    else $error("sample and convert overlap");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_power_copy: assert property (reg_wr && reg_addr == 4'h0 |->
    ##2 core_power_on == $past(reg_wdata[5], 2))
    else $error("power output wrong");
  a_cfg_follow: assert property (reg_wr && reg_addr == 4'h1 |=>
    bandgap_enable == $past(reg_wdata[5]) &&
    ref_source_sel == $past(reg_wdata[4:3]))
    else $error("reference setup wrong");
  a_chan_follow: assert property (reg_wr && reg_addr == 4'h0 |=>
    input_channel_sel == $past(reg_wdata[2:0]))
    else $error("channel wrong");
  a_amp_route: assert property ($stable(input_channel_sel) |->
    sel_overcurrent_amp_output == (input_channel_sel == 3'h2))
    else $error("amplifier routing wrong");
  a_ext_ref: assert property ($stable(ref_source_sel) |->
    ext_ref_connect == (core_power_on && ref_source_sel == 2'h1))
    else $error("external reference wrong");
  a_off_idle: assert property (!core_power_on |=>
    !core_sample && !core_convert)
    else $error("core active while off");
  a_sample_pwr: assert property ($rose(core_sample) |-> core_power_on)
    else $error("sampling without power");
  a_tick_phase: assert property (core_clk_tick |->
    core_sample || core_convert)
    else $error("converter tick outside a conversion");
  c_irq: cover property ($rose(conv_irq));
  c_conv_end: cover property ($fell(core_convert));
  c_amp: cover property ($rose(sel_overcurrent_amp_output));
endmodule // acs_sva
`default_nettype wire

// >>> bench/acs_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer_tb;
  import acs_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [11:0] code_val = 12'h000;
  acs_byte_t reg_rdata;
  logic conv_irq, core_power_on, core_sample, core_convert, core_clk_tick;
  logic sel_overcurrent_amp_output, ext_ref_connect, bandgap_enable;
  logic core_done;
  logic [2:0] input_channel_sel;
  logic [1:0] ref_source_sel;
  logic [11:0] core_code;
  int error_cnt = 0;
  int compares = 0;
  always #50 clk_sys = ~clk_sys;
  acs_sequencer uut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .conv_irq, .core_power_on, .core_sample,
    .core_convert, .core_clk_tick, .input_channel_sel,
    .sel_overcurrent_amp_output, .ref_source_sel, .ext_ref_connect,
    .bandgap_enable, .core_done, .core_code);
  acs_core_model core (.core_power_on, .core_convert, .code_val,
    .core_done, .core_code);
  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // A strobe is dropped at its edge and one idle cycle follows, so no
  // signal is driven twice in one time step.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    acs_byte_t d;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
    @(posedge clk_sys);
    chk({4'h0, d}, {4'h0, e});
  endtask
  task automatic conv(input int dv, input logic al, input logic [11:0] c);
    int n;
    logic [7:0] c0;
    c0 = {3'h1, al, 1'h0, 3'h2};
    code_val <= c;
    wr(4'h1, {3'h1, 2'h1, dv[2:0]});
    wr(4'h0, c0 | 8'h80);
    wr(4'h0, c0);
    n = 1;
    while (n < 5000)
    begin
      @(negedge clk_sys);
      if (conv_irq === 1'b1)
        break;
      @(posedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    // Busy drops and the interrupt rises at the sixteenth divided tick.
    chk(12'(n), 12'(16 << dv));
    rc(4'h0, c0);
    rc(4'h2, al ? {4'h0, c[11:8]} : c[11:4]);
    rc(4'h3, al ? c[7:0] : {c[3:0], 4'h0});
    rc(4'h4, 8'h01);
    wr(4'h4, 8'h01);
    rc(4'h4, 8'h00);
    chk({11'h0, conv_irq}, 12'h000);
  endtask
  initial
  begin
    #2000000;
    error_cnt++;
    end_of_test();
  end
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int a = 0; a < 8; a++)
      rc(a[3:0], 8'h00);
    wr(4'h5, 8'h01);
    wr(4'h0, 8'h20);
    // Settling after power-up is left to software.
    repeat (10) @(posedge clk_sys);
    // Every divider code runs here for coverage, even those whose period
    // lies outside the recommended range; the model has no accuracy limit.
    for (int d = 0; d < 8; d++)
      conv(d, d[0], 12'hFFF - 12'(d * 273));
    wr(4'h5, 8'h00);
    wr(4'h1, 8'h03);
    wr(4'h0, 8'hA0);
    wr(4'h0, 8'h20);
    rc(4'h0, 8'h60);
    wr(4'h0, 8'hA0);
    rc(4'h0, 8'hA0);
    wr(4'h0, 8'h20);
    rc(4'h0, 8'h60);
    repeat (130) @(posedge clk_sys);
    rc(4'h0, 8'h20);
    rc(4'h4, 8'h01);
    chk({11'h0, conv_irq}, 12'h000);
    rc(4'h2, code_val[11:4]);
    wr(4'h0, 8'h00);
    rc(4'h2, 8'h00);
    rc(4'h3, 8'h00);
    chk({11'h0, core_power_on}, 12'h000);
    end_of_test();
  end
endmodule // acs_sequencer_tb
bind acs_sequencer acs_sva chk_i (.clk_sys, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .conv_irq, .core_power_on, .core_sample,
  .core_convert, .core_clk_tick, .input_channel_sel,
  .sel_overcurrent_amp_output, .ref_source_sel, .ext_ref_connect,
  .bandgap_enable);
`default_nettype wire
